// ---- common/nvm_access_pkg.sv ----
// Constants for the nonvolatile memory self-access controller
`default_nettype none
package nvm_access_pkg;
  localparam int CLOCK_MHZ = 40;
  localparam int APB_ADDR_WIDTH = 8;
  // Register byte addresses on the APB slave
  localparam logic [7:0] ADDR_ACCESS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_SEQUENCE_KEY = 8'h04;
  localparam logic [7:0] ADDR_DATA_LOW = 8'h08;
  localparam logic [7:0] ADDR_DATA_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_ADDR_LOW = 8'h10;
  localparam logic [7:0] ADDR_ADDR_HIGH = 8'h14;
  localparam logic [7:0] ADDR_FLAG = 8'h18;
  // Field positions in mem_access_control; BIT_DONE is in the flag register
  localparam int BIT_SPACE = 7;
  localparam int BIT_ROW_ERASE = 4;
  localparam int BIT_ABORT = 3;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_WRITE = 1;
  localparam int BIT_READ = 0;
  localparam int BIT_DONE = 0;
  // Unlock keys, plain defaults
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // Geometry
  localparam int DATA_BYTES = 256;
  localparam int FLASH_WORDS = 2048;
  localparam int BLOCK_WORDS = 4;
  localparam int ROW_WORDS = 32;
  localparam logic [7:0] SMALL_DATA_TOP_BIT = 8'h80;
  localparam logic [12:0] FLASH_MASK_SMALL = 13'h03FF;
  localparam logic [12:0] FLASH_MASK_LARGE = 13'h07FF;
  localparam logic [1:0] LAST_IN_BLOCK = 2'h3;
  localparam logic [13:0] ERASED_WORD = 14'h3FFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Erase/write time in microseconds
  localparam int WRITE_TIME_US = 2;
  localparam int TIMER_WIDTH = 16;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_BURN = 4'b0100,
    ST_FINISH = 4'b1000
  } seq_state_type;
endpackage
`default_nettype wire

// ---- common/nvm_store_if.sv ----
// Request and answer bundle between the controller and a memory array
`default_nettype none
interface nvm_store_if;
  logic [12:0] addr;
  logic [13:0] wdata;
  logic rd_en;
  logic latch_en;
  logic wr_en;
  logic erase_row;
  logic [13:0] rdata;
  modport ctrl (output addr, output wdata, output rd_en, output latch_en, output wr_en,
    output erase_row, input rdata);
  modport store (input addr, input wdata, input rd_en, input latch_en, input wr_en,
    input erase_row, output rdata);
endinterface
`default_nettype wire

// ---- design/data_eeprom_store.sv ----
// Byte-wide data EEPROM array
`default_nettype none
module data_eeprom_store (
  input wire logic clock,
  nvm_store_if.store port
);
  logic [7:0] mem [nvm_access_pkg::DATA_BYTES];
  logic [7:0] rbyte;

  // Overwriting a byte stands in for the automatic erase then program
  always_ff @(posedge clock) begin
    if (port.wr_en) begin
      mem[port.addr[7:0]] <= port.wdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (port.rd_en) begin
      rbyte <= mem[port.addr[7:0]];
    end
  end

  assign port.rdata = {6'h00, rbyte};
endmodule
`default_nettype wire

// ---- design/program_flash_store.sv ----
// Word-wide program flash array with a four-word write latch
`default_nettype none
module program_flash_store (
  input wire logic clock,
  nvm_store_if.store port
);
  logic [13:0] mem [nvm_access_pkg::FLASH_WORDS];
  logic [13:0] latch [nvm_access_pkg::BLOCK_WORDS];
  logic [13:0] rword;
  wire [10:0] word_addr = port.addr[10:0];

  always_ff @(posedge clock) begin
    if (port.latch_en) begin
      latch[word_addr[1:0]] <= port.wdata;
    end
  end

  // Whole four-word block burned at once; erase clears the 32-word row
  always_ff @(posedge clock) begin
    if (port.erase_row) begin
      for (int i = 0; i < nvm_access_pkg::ROW_WORDS; i++) begin
        mem[{word_addr[10:5], i[4:0]}] <= nvm_access_pkg::ERASED_WORD;
      end
    end else if (port.wr_en) begin
      for (int i = 0; i < nvm_access_pkg::BLOCK_WORDS; i++) begin
        mem[{word_addr[10:2], i[1:0]}] <= latch[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (port.rd_en) begin
      rword <= mem[word_addr];
    end
  end

  assign port.rdata = rword;
endmodule
`default_nettype wire

// ---- design/nvm_self_access.sv ----
// APB controlled self-access to data EEPROM and program flash
`default_nettype none
module nvm_self_access #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int WRITE_TIME_US = nvm_access_pkg::WRITE_TIME_US
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [nvm_access_pkg::APB_ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_timeout,
  input wire logic code_protect,
  input wire logic program_write_protect,
  input wire logic programmer_request,
  output logic programmer_access_grant,
  output logic charge_pump_on,
  output logic write_busy
);
  localparam int BURN_CYCLES_INT = WRITE_TIME_US * nvm_access_pkg::CLOCK_MHZ;
  localparam logic [nvm_access_pkg::TIMER_WIDTH-1:0] BURN_CYCLES =
    BURN_CYCLES_INT[nvm_access_pkg::TIMER_WIDTH-1:0];

  nvm_store_if data_port ();
  nvm_store_if flash_port ();

  data_eeprom_store data_store (
    .clock(clock),
    .port(data_port)
  );

  program_flash_store flash_store (
    .clock(clock),
    .port(flash_port)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts once stages two and three agree

  logic [2:0] ext_sync;
  logic [2:0] wdt_sync;
  logic [2:0] prog_sync;
  logic ext_level;
  logic wdt_level;
  logic prog_level;
  logic ext_seen;
  logic wdt_seen;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_sync <= 3'h7;
      wdt_sync <= 3'h0;
      prog_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], external_reset_pin_n};
      wdt_sync <= {wdt_sync[1:0], watchdog_timeout};
      prog_sync <= {prog_sync[1:0], programmer_request};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_level <= 1'b1;
      wdt_level <= 1'b0;
      prog_level <= 1'b0;
    end else begin
      if (ext_sync[1] == ext_sync[2]) ext_level <= ext_sync[2];
      if (wdt_sync[1] == wdt_sync[2]) wdt_level <= wdt_sync[2];
      if (prog_sync[1] == prog_sync[2]) prog_level <= prog_sync[2];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_seen <= 1'b1;
      wdt_seen <= 1'b0;
    end else begin
      ext_seen <= ext_level;
      wdt_seen <= wdt_level;
    end
  end

  // A falling reset pin or a rising watchdog time-out is a warm reset
  wire warm_reset = (ext_seen & ~ext_level) | (wdt_level & ~wdt_seen);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic space_program;
  logic row_erase;
  logic abort_flag;
  logic write_permit;
  logic write_strobe;
  logic read_strobe;
  logic done_flag;
  logic [7:0] data_low;
  logic [5:0] data_high;
  logic [7:0] addr_low;
  logic [4:0] addr_high;
  logic key_step;
  logic key_armed;
  nvm_access_pkg::seq_state_type state;
  nvm_access_pkg::seq_state_type next_state;
  logic [nvm_access_pkg::TIMER_WIDTH-1:0] timer;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire access = psel & penable & pready;
  wire wr_access = access & pwrite;
  wire hit_ctrl = paddr == nvm_access_pkg::ADDR_ACCESS_CONTROL;
  wire hit_key = paddr == nvm_access_pkg::ADDR_SEQUENCE_KEY;
  wire hit_dlow = paddr == nvm_access_pkg::ADDR_DATA_LOW;
  wire hit_dhigh = paddr == nvm_access_pkg::ADDR_DATA_HIGH;
  wire hit_alow = paddr == nvm_access_pkg::ADDR_ADDR_LOW;
  wire hit_ahigh = paddr == nvm_access_pkg::ADDR_ADDR_HIGH;
  wire hit_flag = paddr == nvm_access_pkg::ADDR_FLAG;
  wire mapped = hit_ctrl | hit_key | hit_dlow | hit_dhigh | hit_alow | hit_ahigh | hit_flag;
  wire idle = state == nvm_access_pkg::ST_IDLE;
  wire ctrl_wr = wr_access & hit_ctrl;
  wire key_wr = wr_access & hit_key;

  wire [7:0] ctrl_value = {space_program, 2'h0, row_erase, abort_flag, write_permit,
    write_strobe, read_strobe};

  logic [7:0] read_value;
  always_comb begin
    read_value = 8'h00;
    case (1'b1)
      hit_ctrl: read_value = ctrl_value;
      hit_dlow: read_value = data_low;
      hit_dhigh: read_value = {2'h0, data_high};
      hit_alow: read_value = addr_low;
      hit_ahigh: read_value = {3'h0, addr_high};
      hit_flag: read_value = {7'h00, done_flag};
      default: read_value = 8'h00; // Key register has no storage
    endcase
  end

  // One wait state: pready rises in the second access-phase cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata <= (psel & penable & ~pready & ~pwrite) ? {24'h00_0000, read_value} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address shaping

  wire [12:0] prog_addr_raw = {addr_high, addr_low};
  wire [12:0] prog_mask = LARGE_VARIANT ? nvm_access_pkg::FLASH_MASK_LARGE :
    nvm_access_pkg::FLASH_MASK_SMALL;
  wire [12:0] prog_addr = prog_addr_raw & prog_mask;
  // Data space uses only the low byte; on the small part a set top bit marks the byte unimplemented
  wire data_unimpl = ~LARGE_VARIANT & |(addr_low & nvm_access_pkg::SMALL_DATA_TOP_BIT);
  wire [12:0] data_addr = {5'h00, addr_low};
  wire block_end = prog_addr[1:0] == nvm_access_pkg::LAST_IN_BLOCK;
  wire prog_locked = code_protect & program_write_protect;
  // Writes with no real target still finish, but never power the pump
  wire burn_allowed = space_program ? ~prog_locked : ~data_unimpl;
  wire needs_burn = space_program ? (row_erase | block_end) : 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  wire timer_done = timer == BURN_CYCLES - 1'b1;
  wire start_write = idle & write_strobe;
  wire start_read = idle & ~write_strobe & read_strobe;

  always_comb begin
    next_state = state;
    case (state)
      nvm_access_pkg::ST_IDLE: begin
        if (start_write) begin
          next_state = (needs_burn & burn_allowed) ? nvm_access_pkg::ST_BURN :
            nvm_access_pkg::ST_FINISH;
        end else if (start_read) begin
          next_state = nvm_access_pkg::ST_READ;
        end
      end
      nvm_access_pkg::ST_READ: next_state = nvm_access_pkg::ST_IDLE;
      nvm_access_pkg::ST_BURN: begin
        if (timer_done) next_state = nvm_access_pkg::ST_FINISH;
      end
      nvm_access_pkg::ST_FINISH: next_state = nvm_access_pkg::ST_IDLE;
      default: next_state = nvm_access_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n || warm_reset) begin
      state <= nvm_access_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Write time counted on the internal clock
  always_ff @(posedge clock) begin
    if (!rst_n || state != nvm_access_pkg::ST_BURN) begin
      timer <= '0;
    end else begin
      timer <= timer + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Array requests; the commit lands at the end so an aborted write changes nothing

  wire burn_end = (state == nvm_access_pkg::ST_BURN) & timer_done & ~warm_reset;
  assign data_port.addr = data_addr;
  assign data_port.wdata = {6'h00, data_low};
  assign data_port.rd_en = start_read & ~space_program;
  assign data_port.latch_en = 1'b0;
  assign data_port.wr_en = burn_end & ~space_program;
  assign data_port.erase_row = 1'b0;
  assign flash_port.addr = prog_addr;
  assign flash_port.wdata = {data_high, data_low};
  assign flash_port.rd_en = start_read & space_program;
  assign flash_port.latch_en = start_write & space_program & ~row_erase;
  assign flash_port.wr_en = burn_end & space_program & ~row_erase;
  assign flash_port.erase_row = burn_end & space_program & row_erase;

  wire [13:0] read_word = space_program ? flash_port.rdata :
    (data_unimpl ? 14'h0000 : data_port.rdata);

  ////////////////////////////////////////////////////////////////////////////////
  // Unlock sequence: two key writes, then the strobe must be the very next write

  wire any_wr = wr_access;
  wire strobe_req = ctrl_wr & pwdata[nvm_access_pkg::BIT_WRITE];

  always_ff @(posedge clock) begin
    if (!rst_n || warm_reset) begin
      key_step <= 1'b0;
      key_armed <= 1'b0;
    end else if (any_wr) begin
      key_step <= key_wr & (pwdata[7:0] == nvm_access_pkg::KEY_FIRST);
      key_armed <= key_wr & key_step & (pwdata[7:0] == nvm_access_pkg::KEY_SECOND);
    end
  end

  wire write_accept = strobe_req & key_armed & write_permit & idle;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register

  always_ff @(posedge clock) begin
    if (!rst_n || warm_reset) begin
      space_program <= 1'b0;
      row_erase <= 1'b0;
      write_permit <= 1'b0;
    end else if (ctrl_wr && idle && !write_strobe) begin
      space_program <= pwdata[nvm_access_pkg::BIT_SPACE];
      row_erase <= pwdata[nvm_access_pkg::BIT_ROW_ERASE];
      write_permit <= pwdata[nvm_access_pkg::BIT_PERMIT];
    end
  end

  // Strobes: software can only set them, completion clears them
  always_ff @(posedge clock) begin
    if (!rst_n || warm_reset) begin
      write_strobe <= 1'b0;
      read_strobe <= 1'b0;
    end else begin
      if (write_accept) begin
        write_strobe <= 1'b1;
      end else if (state == nvm_access_pkg::ST_FINISH) begin
        write_strobe <= 1'b0;
      end
      if (ctrl_wr && pwdata[nvm_access_pkg::BIT_READ] && idle && !write_strobe) begin
        read_strobe <= 1'b1;
      end else if (state == nvm_access_pkg::ST_READ) begin
        read_strobe <= 1'b0;
      end
    end
  end

  // Abort flag survives the warm reset that sets it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      abort_flag <= 1'b0;
    end else if (warm_reset && (state == nvm_access_pkg::ST_BURN)) begin
      abort_flag <= 1'b1;
    end else if (ctrl_wr) begin
      abort_flag <= pwdata[nvm_access_pkg::BIT_ABORT];
    end
  end

  // Completion wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      done_flag <= 1'b0;
    end else if (state == nvm_access_pkg::ST_FINISH) begin
      done_flag <= 1'b1;
    end else if (wr_access && hit_flag && !pwdata[nvm_access_pkg::BIT_DONE]) begin
      done_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data and address registers; no warm reset term so a retry finds them intact

  wire data_lock = ~idle | write_strobe;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      data_low <= 8'h00;
      data_high <= 6'h00;
      addr_low <= 8'h00;
      addr_high <= 5'h00;
    end else if (state == nvm_access_pkg::ST_READ) begin
      data_low <= read_word[7:0];
      data_high <= space_program ? read_word[13:8] : data_high;
    end else if (wr_access && !data_lock) begin
      if (hit_dlow) data_low <= pwdata[7:0];
      if (hit_dhigh) data_high <= pwdata[5:0];
      if (hit_alow) addr_low <= pwdata[7:0];
      if (hit_ahigh) addr_high <= pwdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status outputs

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      charge_pump_on <= 1'b0;
      write_busy <= 1'b0;
      programmer_access_grant <= 1'b0;
    end else begin
      charge_pump_on <= (next_state == nvm_access_pkg::ST_BURN) & ~warm_reset;
      write_busy <= write_strobe | write_accept;
      // Internal paths do not look at this grant
      programmer_access_grant <= prog_level & ~code_protect;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/nvm_pin_model.sv ----
// Model of the reset pin and watchdog outside the controller
`default_nettype none
module nvm_pin_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic use_watchdog,
  output logic external_reset_pin_n,
  output logic watchdog_timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hold;
  // Held for eight clocks so the three-stage synchroniser cannot miss it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold <= 4'h0;
    end else if (fire) begin
      hold <= 4'h8;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
  end
  assign external_reset_pin_n = !(hold != 4'h0 && !use_watchdog);
  assign watchdog_timeout = hold != 4'h0 && use_watchdog;
endmodule
`default_nettype wire

// ---- testbench/nvm_self_access_sva.sv ----
// Port-level checker for the self-access controller
`default_nettype none
module nvm_self_access_checker #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int WRITE_TIME_US = nvm_access_pkg::WRITE_TIME_US
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [nvm_access_pkg::APB_ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_timeout,
  input wire logic code_protect,
  input wire logic program_write_protect,
  input wire logic programmer_request,
  input wire logic programmer_access_grant,
  input wire logic charge_pump_on,
  input wire logic write_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BURN = WRITE_TIME_US * nvm_access_pkg::CLOCK_MHZ;
  logic [9:0] pump_count;
  logic [7:0] quiet;
  ////////////////////////////////////////////////////////////////////////////////
  // Burn length is only exact when no warm reset cut it short
  always_ff @(posedge clock) begin
    if (!rst_n || !charge_pump_on) begin
      pump_count <= 10'h000;
    end else begin
      pump_count <= pump_count + 10'h001;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n || !external_reset_pin_n || watchdog_timeout) begin
      quiet <= 8'h00;
    end else if (quiet != 8'hFF) begin
      quiet <= quiet + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  ready_one_wait_a: assert property (
    psel && penable && !$past(penable) |=> pready ##1 !pready)
    else $error("pready not one cycle after access start");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  read_idle_zero_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero between answers");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  key_reads_zero_a: assert property (
    pready && !pwrite && paddr == nvm_access_pkg::ADDR_SEQUENCE_KEY |-> prdata == 32'h0)
    else $error("key register read not zero");
  grant_denied_a: assert property (code_protect [*3] |-> !programmer_access_grant)
    else $error("programmer granted under code protection");
  grant_given_a: assert property (
    (!code_protect && programmer_request) [*6] |-> programmer_access_grant)
    else $error("programmer not granted without protection");
  pump_with_busy_a: assert property (charge_pump_on |-> write_busy)
    else $error("charge pump on while not busy");
  pump_limit_a: assert property (pump_count <= BURN)
    else $error("charge pump on too long");
  burn_time_a: assert property (
    $fell(charge_pump_on) && quiet > 8'h64 |-> pump_count == BURN)
    else $error("burn length wrong");
  power_up_idle_a: assert property (
    $rose(rst_n) |-> !write_busy && !charge_pump_on && !pready)
    else $error("outputs not idle after reset");
endmodule
bind nvm_self_access nvm_self_access_checker #(.LARGE_VARIANT(LARGE_VARIANT),
  .WRITE_TIME_US(WRITE_TIME_US)) i_checker (.clock(clock), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .external_reset_pin_n(external_reset_pin_n),
  .watchdog_timeout(watchdog_timeout), .code_protect(code_protect),
  .program_write_protect(program_write_protect), .programmer_request(programmer_request),
  .programmer_access_grant(programmer_access_grant), .charge_pump_on(charge_pump_on),
  .write_busy(write_busy));
`default_nettype wire

// ---- testbench/nvm_self_access_test.sv ----
// Self-checking bench for the self-access controller, small variant
`default_nettype none
module nvm_self_access_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = nvm_access_pkg::ADDR_ACCESS_CONTROL;
  localparam logic [7:0] KEY = nvm_access_pkg::ADDR_SEQUENCE_KEY;
  localparam logic [7:0] DLO = nvm_access_pkg::ADDR_DATA_LOW;
  localparam logic [7:0] DHI = nvm_access_pkg::ADDR_DATA_HIGH;
  localparam logic [7:0] ALO = nvm_access_pkg::ADDR_ADDR_LOW;
  localparam logic [7:0] AHI = nvm_access_pkg::ADDR_ADDR_HIGH;
  localparam logic [7:0] FLG = nvm_access_pkg::ADDR_FLAG;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, rerr, pump_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic pin_n, wdt, code_protect, write_protect, prog_req, grant, pump, write_busy;
  logic fire, use_wdt;
  int n_errors = 0;
  int n_tests = 0;
  nvm_self_access #(.LARGE_VARIANT(1'b0), .WRITE_TIME_US(2)) i_dut (.clock(clock),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_reset_pin_n(pin_n), .watchdog_timeout(wdt), .code_protect(code_protect),
    .program_write_protect(write_protect), .programmer_request(prog_req),
    .programmer_access_grant(grant), .charge_pump_on(pump), .write_busy(write_busy));
  nvm_pin_model i_pins (.clock(clock), .rst_n(rst_n), .fire(fire), .use_watchdog(use_wdt),
    .external_reset_pin_n(pin_n), .watchdog_timeout(wdt));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (pump === 1'b1) pump_seen <= 1'b1;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h", $time, msg, got);
    end
  endtask
  // Holds the request until pready is sampled high, then idles one cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clock);
    end
    rdata = prdata;
    rerr = pslverr;
    chk({31'h0, pready}, 32'h1, "no bus answer");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp,
    input string msg);
    apb(1'b0, a, 32'h0);
    chk(rdata & mask, exp, msg);
  endtask
  task automatic start(input logic [7:0] c, input logic keys);
    pump_seen = 1'b0;
    wr(CTL, c | 8'h04);
    if (keys) begin
      wr(KEY, nvm_access_pkg::KEY_FIRST);
      wr(KEY, nvm_access_pkg::KEY_SECOND);
    end
    wr(CTL, c | 8'h06);
  endtask
  task automatic wait_idle(input logic exp_pump, input string msg);
    int n;
    n = 0;
    while (write_busy !== 1'b0 && n < 400) begin
      n++;
      @(posedge clock);
    end
    chk({31'h0, write_busy}, 32'h0, "busy stuck");
    chk({31'h0, pump_seen}, {31'h0, exp_pump}, msg);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("CHECK FAILED at %0t: run did not end", $time);
    finish_test();
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pump_seen} = '0;
    {code_protect, write_protect, prog_req, fire, use_wdt} = '0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(CTL, 32'h87, 32'h0, "control after reset");
    rd(KEY, 32'hFFFF_FFFF, 32'h0, "key reads zero");
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped no error");
    $display("test reset done");
    wr(ALO, 8'h05);
    wr(DLO, 8'h3C);
    start(8'h00, 1'b0);
    wait_idle(1'b0, "write without keys burned");
    rd(FLG, 32'h1, 32'h0, "done without write");
    start(8'h00, 1'b1);
    wr(CTL, 8'h04);
    rd(CTL, 32'h2, 32'h2, "strobe cleared by software");
    wait_idle(1'b1, "data write no burn");
    rd(CTL, 32'h2, 32'h0, "strobe not cleared");
    rd(FLG, 32'h1, 32'h1, "done not set");
    wr(FLG, 8'h00);
    rd(FLG, 32'h1, 32'h0, "done not cleared");
    wr(DLO, 8'h00);
    wr(CTL, 8'h01);
    rd(DLO, 32'hFF, 32'h3C, "data read back");
    $display("test data write done");
    wr(ALO, 8'h85);
    wr(DLO, 8'h5A);
    start(8'h00, 1'b1);
    wait_idle(1'b0, "pump on for unimplemented byte");
    wr(CTL, 8'h01);
    rd(DLO, 32'hFF, 32'h00, "unimplemented byte not zero");
    $display("test unimplemented done");
    wr(AHI, 8'h00);
    wr(ALO, 8'h00);
    start(8'h90, 1'b1);
    wait_idle(1'b1, "row erase no burn");
    for (int i = 0; i < 4; i++) begin
      wr(DLO, 8'h34 + 8'(i));
      wr(DHI, 8'h12 + 8'(i));
      wr(ALO, 8'(i));
      start(8'h80, 1'b1);
      wait_idle(i == 3, "flash block burn wrong");
    end
    wr(AHI, 8'h04);
    wr(ALO, 8'h02);
    wr(CTL, 8'h81);
    rd(DLO, 32'hFF, 32'h36, "flash low byte");
    rd(DHI, 32'h3F, 32'h14, "flash high bits");
    $display("test flash done");
    code_protect <= 1'b1;
    write_protect <= 1'b1;
    prog_req <= 1'b1;
    wr(AHI, 8'h00);
    wr(ALO, 8'h07);
    start(8'h80, 1'b1);
    wait_idle(1'b0, "protected flash burned");
    wr(ALO, 8'h06);
    start(8'h00, 1'b1);
    wait_idle(1'b1, "protected data not burned");
    chk({31'h0, grant}, 32'h0, "grant under protection");
    code_protect <= 1'b0;
    repeat (8) @(posedge clock);
    chk({31'h0, grant}, 32'h1, "grant missing");
    prog_req <= 1'b0;
    $display("test protection done");
    for (int s = 0; s < 2; s++) begin
      wr(ALO, 8'h07);
      wr(DLO, 8'h11 + 8'(s));
      start(8'h00, 1'b1);
      repeat (20) @(posedge clock);
      use_wdt <= s[0];
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      repeat (30) @(posedge clock);
      rd(CTL, 32'h0A, 32'h08, "abort flag or strobe");
      rd(ALO, 32'hFF, 32'h07, "address lost");
      rd(DLO, 32'hFF, 32'h11 + s, "data lost");
      wr(CTL, 8'h00);
    end
    $display("test abort done");
    finish_test();
  end
endmodule
`default_nettype wire
